// >>> logic/dpw_pin_sync.sv
// Purpose: Three-stage synchroniser for the RAM data pins.
// Assumes: Pins settle well before they are used.
// Notes:   Output moves only when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module dpw_pin_sync #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Data
    input  wire logic [W-1:0] din,
    output var  logic [W-1:0] dout
);
    logic [W-1:0] s1_q, s2_q, s3_q, out_q, out_d;

    always_comb begin
        out_d = (s2_q == s3_q) ? s3_q : out_q;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            out_q <= '0;
        end else begin
            s1_q  <= din;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            out_q <= out_d;
        end
    end

    assign dout = out_q;
endmodule
`default_nettype wire

// >>> logic/dpw_pkg.sv
// Purpose: Shared constants and types for the dual-port RAM port master.
// Assumes: One 125 MHz clock. Timing figures are those of the 25 ns speed grade.
// Notes:   Times below are held in ns, except SYNC_LAT in cycles; cycle counts are derived from them.
//
// What this block does
// - The array is selected by chip select and a lane low with flag select high; a flag by chip select high and flag select low, held over the whole pulse.
// - The write strobe or chip select stays high whenever the address changes.
// - The master does not drive data while the RAM may still drive its pins.
// - With output enable low the write pulse is the larger of the pulse width and turn-off plus data setup.
// - Write data are held at least the hold time after the end of write.
// - A flag is read back no sooner than the write-to-read time after it was written, the array deselected throughout.
package dpw_pkg;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 16;
    localparam int CLK_NS = 8;

    // --------------------------------------------------------------
    // Timing in ns, synchroniser latency in cycles
    // --------------------------------------------------------------
    localparam int T_WC_NS   = 25;
    localparam int T_EW_NS   = 20;
    localparam int T_WP_NS   = 20;
    localparam int T_WR_NS   = 0;
    localparam int T_DW_NS   = 15;
    localparam int T_DH_NS   = 0;
    localparam int T_WZ_NS   = 15;
    localparam int T_SWRD_NS = 5;
    localparam int T_AA_NS   = 25;
    localparam int SYNC_LAT  = 4;

    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int max_int(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    // --------------------------------------------------------------
    // Cycle counts
    // --------------------------------------------------------------
    localparam int CYC_PULSE = max_int(max_int(ns_to_cyc(T_WP_NS), ns_to_cyc(T_EW_NS)),
                                       ns_to_cyc(T_WZ_NS + T_DW_NS));
    localparam int CYC_HOLD  = ns_to_cyc(T_DH_NS);
    localparam int CYC_REC   = max_int(ns_to_cyc(T_WR_NS),
                                       ns_to_cyc(T_WC_NS) - CYC_PULSE - 1);
    localparam int CYC_SWRD  = ns_to_cyc(T_SWRD_NS);
    localparam int CYC_READ  = ns_to_cyc(T_AA_NS) + SYNC_LAT;

    localparam logic [1:0] LANES_OFF = 2'h3;

    typedef enum logic [1:0] {
        DPW_ARRAY_WR,
        DPW_ARRAY_RD,
        DPW_FLAG_WR,
        DPW_FLAG_RD
    } dpw_op_e;

    typedef struct packed {
        dpw_op_e             op;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
        logic [1:0]          lanes;   // Bit 1 upper, bit 0 lower, high = use
    } dpw_cmd_s;

    typedef struct packed {
        logic                valid;
        logic [DATA_W-1:0]   data;
        logic                flag;
    } dpw_rsp_s;

    typedef struct packed {
        logic [ADDR_W-1:0]   addr;
        logic                chip_sel_n;
        logic                upper_lane_select_n;
        logic                lower_lane_select_n;
        logic                rw_n;
        logic                flag_select_n;
        logic                out_en_n;
        logic [DATA_W-1:0]   dq_o;
        logic                dq_oe;
    } dpw_pin_s;
endpackage

// >>> logic/dpw_port_master.sv
// Purpose: Drives one port of the dual-port RAM for array and flag accesses.
// Assumes: Pins are direct; the RAM is asynchronous; one command at a time.
// Notes:   Output enable stays high on writes so the data pins never fight.
`timescale 1ns/1ps
`default_nettype none
module dpw_port_master
    import dpw_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // Command side
    input  wire logic                  cmd_valid,
    input  wire dpw_pkg::dpw_cmd_s     cmd,
    output var  logic                  cmd_ready,
    output var  dpw_pkg::dpw_rsp_s     rsp,
    // RAM port pins
    output var  dpw_pkg::dpw_pin_s     pins,
    input  wire logic [DATA_W-1:0]     dq_i
);
    import dpw_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD,
        ST_RECOV
    } dpw_state_e;

    // The first strobe cycle only lowers the selects, so the counts run one further
    localparam logic [3:0] PULSE_LAST = 4'(CYC_PULSE);
    // A read also waits out the output register behind the synchroniser
    localparam logic [3:0] READ_LAST  = 4'(CYC_READ + 1);
    localparam logic [3:0] HOLD_LAST  = 4'(CYC_HOLD - 1);
    localparam logic [3:0] REC_LAST   = 4'(CYC_REC - 1);
    localparam logic [3:0] SWRD_CNT   = 4'(CYC_SWRD);

    dpw_state_e          state_q, state_d;
    dpw_cmd_s            cur_q, cur_d;
    dpw_pin_s            pins_q, pins_d;
    dpw_rsp_s            rsp_q, rsp_d;
    logic [3:0]          cnt_q, cnt_d;
    logic [3:0]          gap_q, gap_d;
    logic                ready_q, ready_d;
    logic [DATA_W-1:0]   dq_sync;

    dpw_pin_sync #(.W(DATA_W)) u_sync (
        .clk  (clk),
        .rst_n(rst_n),
        .din  (dq_i),
        .dout (dq_sync)
    );

    function automatic logic is_write(input dpw_op_e op);
        return (op == DPW_ARRAY_WR) || (op == DPW_FLAG_WR);
    endfunction

    function automatic logic is_flag(input dpw_op_e op);
        return (op == DPW_FLAG_WR) || (op == DPW_FLAG_RD);
    endfunction

    // --------------------------------------------------------------
    // Sequencer
    // --------------------------------------------------------------
    always_comb begin
        state_d   = state_q;
        cur_d     = cur_q;
        pins_d    = pins_q;
        cnt_d     = cnt_q;
        rsp_d     = rsp_q;
        rsp_d.valid = 1'b0;
        gap_d     = (gap_q != 4'h0) ? gap_q - 4'h1 : 4'h0;
        case (state_q)
            ST_IDLE: begin
                if (cmd_valid && ready_q) begin
                    // Address moves only with every select high
                    cur_d       = cmd;
                    pins_d.addr = cmd.addr;
                    state_d     = ST_SETUP;
                end
            end
            ST_SETUP: begin
                // A flag read waits out the write-to-read time
                if (!(cur_q.op == DPW_FLAG_RD && gap_q != 4'h0)) begin
                    // Strobe falls first so the RAM outputs stay floating
                    pins_d.rw_n     = !is_write(cur_q.op);
                    pins_d.out_en_n = is_write(cur_q.op);
                    pins_d.dq_o     = is_flag(cur_q.op) ? {DATA_W{cur_q.data[0]}} : cur_q.data;
                    // Data driven only while the RAM output enable is high
                    pins_d.dq_oe    = is_write(cur_q.op);
                    cnt_d           = 4'h0;
                    state_d         = ST_STROBE;
                end
            end
            ST_STROBE: begin
                if (is_flag(cur_q.op)) begin
                    // Array kept deselected for the whole flag access
                    pins_d.chip_sel_n          = 1'b1;
                    pins_d.upper_lane_select_n = 1'b1;
                    pins_d.lower_lane_select_n = 1'b1;
                    pins_d.flag_select_n       = 1'b0;
                end else begin
                    pins_d.chip_sel_n          = 1'b0;
                    pins_d.upper_lane_select_n = !cur_q.lanes[1];
                    pins_d.lower_lane_select_n = !cur_q.lanes[0];
                    pins_d.flag_select_n       = 1'b1;
                end
                cnt_d = cnt_q + 4'h1;
                if (is_write(cur_q.op) ? (cnt_q == PULSE_LAST)
                                       : (cnt_q == READ_LAST)) begin
                    pins_d.chip_sel_n          = 1'b1;
                    pins_d.upper_lane_select_n = 1'b1;
                    pins_d.lower_lane_select_n = 1'b1;
                    pins_d.flag_select_n       = 1'b1;
                    pins_d.rw_n                = 1'b1;
                    pins_d.out_en_n            = 1'b1;
                    if (!is_write(cur_q.op)) begin
                        // Every pin carries the flag; bit 0 is taken
                        rsp_d.valid = 1'b1;
                        rsp_d.data  = dq_sync;
                        // A contended flag's winner is only learned from this read back
                        rsp_d.flag  = dq_sync[0];
                    end
                    if (cur_q.op == DPW_FLAG_WR) begin
                        gap_d = SWRD_CNT;
                    end
                    cnt_d   = 4'h0;
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // Data stay on the bus past the end of write
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == HOLD_LAST) begin
                    pins_d.dq_oe = 1'b0;
                    cnt_d        = 4'h0;
                    state_d      = ST_RECOV;
                end
            end
            ST_RECOV: begin
                // Recovery counted from the joint rise of select and strobe
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == REC_LAST) begin
                    cnt_d   = 4'h0;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        ready_d = (state_d == ST_IDLE) && !(state_q == ST_IDLE && cmd_valid && ready_q);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            cur_q   <= '0;
            pins_q  <= '{addr: '0, chip_sel_n: 1'b1, upper_lane_select_n: 1'b1,
                         lower_lane_select_n: 1'b1, rw_n: 1'b1, flag_select_n: 1'b1,
                         out_en_n: 1'b1, dq_o: '0, dq_oe: 1'b0};
            rsp_q   <= '0;
            cnt_q   <= 4'h0;
            gap_q   <= 4'h0;
            ready_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cur_q   <= cur_d;
            pins_q  <= pins_d;
            rsp_q   <= rsp_d;
            cnt_q   <= cnt_d;
            gap_q   <= gap_d;
            ready_q <= ready_d;
        end
    end

    assign pins      = pins_q;
    assign rsp       = rsp_q;
    assign cmd_ready = ready_q;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic       arr_sel, any_sel;
    logic [3:0] low_run_q;
    assign arr_sel = !pins_q.chip_sel_n
                     && !(pins_q.upper_lane_select_n && pins_q.lower_lane_select_n);
    assign any_sel = arr_sel || !pins_q.flag_select_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_run_q <= 4'h0;
        end else begin
            low_run_q <= (any_sel && !pins_q.rw_n) ? low_run_q + 4'h1 : 4'h0;
        end
    end

    a_addr_stable: assert property (
        !$stable(pins_q.addr) |-> $past(pins_q.rw_n) && !$past(any_sel))
        else $error("Address moved during a write strobe");
    a_no_bus_fight: assert property (
        pins_q.dq_oe |-> pins_q.out_en_n)
        else $error("Data driven while RAM output enabled");
    a_strobe_first: assert property (
        $rose(any_sel) && !pins_q.rw_n |-> !$past(pins_q.rw_n))
        else $error("Select fell before the write strobe");
    a_flag_deselect: assert property (
        !pins_q.flag_select_n |-> pins_q.chip_sel_n && pins_q.upper_lane_select_n)
        else $error("Array selected during a flag access");
    a_pulse_width: assert property (
        $fell(any_sel && !pins_q.rw_n) |-> low_run_q == 4'(CYC_PULSE))
        else $error("Write pulse of wrong length");
    a_data_hold: assert property (
        $fell(any_sel && !pins_q.rw_n) |-> pins_q.dq_oe && $stable(pins_q.dq_o))
        else $error("Write data dropped at end of write");
    a_write_overlap: assert property (
        pins_q.dq_oe && arr_sel |-> !pins_q.rw_n ##[1:8] (pins_q.rw_n && pins_q.chip_sel_n))
        else $error("Array write overlap not closed");
    a_flag_gap: assert property (
        $fell(pins_q.flag_select_n) && pins_q.rw_n |-> gap_q == 4'h0)
        else $error("Flag read too soon after flag write");
    a_recovery: assert property (
        state_q == ST_HOLD && state_d == ST_RECOV |-> ##1 (!ready_q)[*1] ##0 pins_q.chip_sel_n)
        else $error("Recovery skipped");
    a_read_result: assert property (
        rsp_q.valid |-> rsp_q.flag == rsp_q.data[0] && $past(state_q) == ST_STROBE)
        else $error("Read result not from the strobe phase");

    c_array_write: cover property ($fell(pins_q.chip_sel_n) && !pins_q.rw_n);
    c_flag_write:  cover property ($fell(pins_q.flag_select_n) && !pins_q.rw_n);
    c_flag_read:   cover property (rsp_q.valid && cur_q.op == DPW_FLAG_RD);
    c_flag_wr_rd:  cover property (cur_q.op == DPW_FLAG_RD && state_q == ST_SETUP
                                   && gap_q != 4'h0);
endmodule
`default_nettype wire

// >>> tb/dpw_port_master_bench.sv
// Purpose: Self-checking bench for the RAM port master against the RAM model.
// Assumes: Seeded random addresses, data, lanes, flag holds and answer delays.
// Notes:   Expected array words come from a byte merge worked out here; flag words come from the flag hold mask.
`timescale 1ns/1ps
`default_nettype none
module dpw_port_master_bench;
    import dpw_pkg::*;
    logic              clk, rst_n, cmd_valid, cmd_ready, dev_oe, viol;
    dpw_cmd_s          cmd;
    dpw_rsp_s          rsp, r;
    dpw_pin_s          pins;
    logic [DATA_W-1:0] dq_dev, dq_i, d, e, pe;
    logic [ADDR_W-1:0] a, pa;
    logic [7:0]        other_hold;
    logic [1:0]        lat, ln;
    int                n_mismatch, checked, seed, cycles;

    assign dq_i = pins.dq_oe ? pins.dq_o : dq_dev;

    dpw_port_master i_dpw_port_master (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_ready(cmd_ready), .rsp(rsp), .pins(pins), .dq_i(dq_i));
    dpw_ram_model i_dpw_ram_model (.clk(clk), .rst_n(rst_n), .pins(pins),
        .other_hold(other_hold), .lat(lat), .dq_dev(dq_dev), .dev_oe(dev_oe), .viol(viol));

    // ----------------------------------------------------------------
    // Clock, watchdog and helpers
    // ----------------------------------------------------------------
    initial clk = 1'b0;
    always #4 clk = ~clk;

    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            n_mismatch = n_mismatch + 1;
            report_and_stop();
        end
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o,
                                                input logic [DATA_W-1:0] n, input logic [1:0] l);
        return {l[1] ? n[15:8] : o[15:8], l[0] ? n[7:0] : o[7:0]};
    endfunction

    // Holds the command until the edge that takes it
    task automatic issue(input dpw_op_e op, input logic [ADDR_W-1:0] ad,
                         input logic [DATA_W-1:0] dt, input logic [1:0] l);
        int k;
        @(posedge clk);
        #1;
        cmd_valid = 1'b1;
        cmd = '{op, ad, dt, l};
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (cmd_ready !== 1'b1 && k < 60);
        // A command never taken is a hang, counted like any other mismatch
        if (cmd_ready !== 1'b1) begin
            n_mismatch = n_mismatch + 1;
        end
        #1;
        cmd_valid = 1'b0;
    endtask

    task automatic rd(input dpw_op_e op, input logic [ADDR_W-1:0] ad);
        int k;
        issue(op, ad, 16'h0000, 2'h3);
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (rsp.valid !== 1'b1 && k < 40);
        r = rsp;
        chk({15'h0000, r.valid}, 16'h0001);
        #1;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 48; rst_n = 1'b0; cmd_valid = 1'b0; cmd = '0; other_hold = 8'h00; lat = 2'h0;
        n_mismatch = 0; checked = 0; cycles = 0; pa = 13'h0000; pe = 16'h0000;
        repeat (6) @(posedge clk);
        chk({pins.chip_sel_n, pins.rw_n, pins.flag_select_n, pins.out_en_n, pins.dq_oe,
             cmd_ready, 10'h000}, 16'hF000);
        #1;
        rst_n = 1'b1;
        for (int i = 0; i < 24; i++) begin
            a = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1FFF : 13'($random(seed));
            d = 16'($random(seed));
            ln = 2'((($random(seed)) & 32'h7FFF) % 3) + 2'h1;
            lat = 2'($random(seed));
            issue(DPW_ARRAY_WR, a, d, 2'h3);
            e = 16'($random(seed));
            issue(DPW_ARRAY_WR, a, e, ln);
            e = merge(d, e, ln);
            rd(DPW_ARRAY_RD, a);
            chk(r.data, e);
            if (i > 0 && pa != a) begin
                rd(DPW_ARRAY_RD, pa);
                chk(r.data, pe);
            end
            pa = a;
            pe = e;
        end
        for (int f = 0; f < 8; f++) begin
            other_hold = 8'($random(seed));
            issue(DPW_FLAG_WR, 13'(f), 16'h0000, 2'h0);
            rd(DPW_FLAG_RD, 13'(f));
            chk(r.data, other_hold[f] ? 16'hFFFF : 16'h0000);
            chk({15'h0000, r.flag}, {15'h0000, other_hold[f]});
            issue(DPW_FLAG_WR, 13'(f), 16'hFFFF, 2'h0);
            rd(DPW_FLAG_RD, 13'(f));
            chk(r.data, 16'hFFFF);
        end
        chk({15'h0000, viol}, 16'h0000);
        report_and_stop();
    end
endmodule
`default_nettype wire

// >>> tb/dpw_ram_model.sv
// Purpose: Behavioural model of one port of the dual-port RAM, array and flags.
// Assumes: Pins are sampled on clk; the other port is reduced to a flag hold mask.
// Notes:   Breaches of the master's obligations set the sticky viol output.
`timescale 1ns/1ps
`default_nettype none
module dpw_ram_model
    import dpw_pkg::*;
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    // Port pins and scenario controls
    input  wire dpw_pkg::dpw_pin_s   pins,
    input  wire logic [7:0]          other_hold,
    input  wire logic [1:0]          lat,
    // Device side of the data pins, and the violation flag
    output var  logic [DATA_W-1:0]   dq_dev,
    output var  logic                dev_oe,
    output var  logic                viol
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] wdata, last;
    logic [ADDR_W-1:0] addr_q;
    logic [7:0]        own_req;
    logic [1:0]        wlanes_n;
    logic              arr_wr, flg_wr, arr_wr_q, flg_wr_q, rd_on, fv;
    int                pulse, rd_cnt, since_flag;

    // Array write needs chip select, strobe and a lane low together; flag write needs flag select and strobe
    assign arr_wr = !pins.chip_sel_n && !pins.rw_n && pins.flag_select_n
                    && !(pins.upper_lane_select_n && pins.lower_lane_select_n);
    assign flg_wr = !pins.flag_select_n && !pins.rw_n;
    // Drivers only turn on with the strobe high, so a write never sees them
    assign rd_on  = pins.rw_n && !pins.out_en_n
                    && (!pins.flag_select_n || !pins.chip_sel_n);
    // Flag reads low only when this side holds it; the other side wins ties
    assign fv     = !(own_req[pins.addr[2:0]] && !other_hold[pins.addr[2:0]]);
    // Released pins show the inverse of the last value, never a stale copy
    assign dq_dev = !dev_oe ? ~last
                  : !pins.flag_select_n ? {DATA_W{fv}} : mem[pins.addr];

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            own_req <= 8'h00; pulse <= 0; rd_cnt <= 0; since_flag <= 100; viol <= 1'b0;
            arr_wr_q <= 1'b0; flg_wr_q <= 1'b0; last <= 16'h0000; dev_oe <= 1'b0;
        end else begin
            addr_q   <= pins.addr;
            arr_wr_q <= arr_wr;
            flg_wr_q <= flg_wr;
            last     <= dq_dev;
            since_flag <= since_flag + 1;
            if ((arr_wr || flg_wr) && (arr_wr_q || flg_wr_q) && pins.addr != addr_q)
                viol <= 1'b1;
            if (!pins.flag_select_n && !pins.chip_sel_n
                && !(pins.upper_lane_select_n && pins.lower_lane_select_n))
                viol <= 1'b1;
            if (dev_oe && pins.dq_oe)
                viol <= 1'b1;
            if (arr_wr || flg_wr) begin
                pulse    <= pulse + 1;
                wdata    <= pins.dq_o;
                wlanes_n <= {pins.upper_lane_select_n, pins.lower_lane_select_n};
                if (!pins.dq_oe) viol <= 1'b1;
            end else begin
                pulse <= 0;
            end
            // End of write is the first strobe to rise
            if ((arr_wr_q && !arr_wr) || (flg_wr_q && !flg_wr)) begin
                if (pulse * CLK_NS < T_WP_NS || !pins.dq_oe)
                    viol <= 1'b1;
                if (arr_wr_q && !wlanes_n[0]) mem[addr_q][7:0] <= wdata[7:0];
                if (arr_wr_q && !wlanes_n[1]) mem[addr_q][15:8] <= wdata[15:8];
                if (flg_wr_q) begin
                    own_req[addr_q[2:0]] <= !wdata[0];
                    since_flag <= 0;
                end
            end
            if (rd_on) begin
                rd_cnt <= rd_cnt + 1;
                if (!pins.flag_select_n && rd_cnt == 0 && since_flag * CLK_NS < T_SWRD_NS)
                    viol <= 1'b1;
            end else begin
                rd_cnt <= 0;
            end
            dev_oe <= rd_on && rd_cnt >= int'(lat);
        end
    end
endmodule
`default_nettype wire
